// file: hw/qtb_timer_block.sv
// quadrature timer block top: core timer, two aux timers, apb slave
//
// Notes on behaviour
// R1 - mode 110 or 111 selects encoder mode
// R2 - select field picks counting edges, 000 stops
// R3 - direction from edge and other phase
// R4 - mode 110 interrupts on direction change
// R5 - mode 111 interrupts on every count
// R6 - direction, change and count flags readable
// R7 - software enables external direction, pins inputs
// R8 - inputs held four clocks, max clk/8
// R9 - aux timers identical, core timer options
// R10 - common control bits share positions
// R11 - aux run from own or core bit
// R12 - aux timers lack output and latch
// R13 - aux select picks input or latch edge
// R14 - only hardware latch toggles clock aux
// R15 - both edges 32 bit, one edge 33
// R16 - all timers sixteen bits wide
// R17 - concatenated timers keep own direction
// R18 - overflow toggles latch, software may write
// R19 - core run bit starts and stops
// R20 - inputs synchronised before edge detect
// R21 - timers wrap modulo 65536
`timescale 1ns/100ps
`default_nettype none
module qtb_timer_block
	import qtb_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        coreCountIn,
	input  wire logic        coreDirIn,
	input  wire logic        aux1CountIn,
	input  wire logic        aux1DirIn,
	input  wire logic        aux2CountIn,
	input  wire logic        aux2DirIn,
	output logic             toggleOut,
	output logic             coreIrq
);

	// ********************************************************
	// input synchronisers
	// ********************************************************
	logic [PIN_COUNT-1:0] pins;
	logic [PIN_COUNT-1:0] sLvl;
	logic [PIN_COUNT-1:0] sRise;
	logic [PIN_COUNT-1:0] sFall;

	assign pins = {aux2DirIn, aux2CountIn, aux1DirIn, aux1CountIn,
		coreDirIn, coreCountIn};

	// R20 synchronise all pins
	// R8 four-clock hold covers the filter
	qtb_pin_sync #(
		.W(PIN_COUNT)
	) u_sync (
		.clk_sys(clk_sys),
		.rst_b  (rst_b),
		.pinIn  (pins),
		.lvl    (sLvl),
		.rise   (sRise),
		.fall   (sFall)
	);

	// ********************************************************
	// prescaler
	// ********************************************************
	logic [PRE_WIDTH-1:0] preCnt_q;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			preCnt_q <= '0;
		end else begin
			preCnt_q <= preCnt_q + 10'h001;
		end
	end

	// ********************************************************
	// apb decode
	// ********************************************************
	logic        apbWr;
	logic        coreCtlWr;
	logic        coreValWr;
	logic [1:0]  auxCtlWr;
	logic [1:0]  auxValWr;
	logic        mapped;

	// writes land at the access edge while pready is high
	assign apbWr     = psel & penable & pready & pwrite;
	assign coreCtlWr = apbWr & (paddr == ADDR_CORE_CTL);
	assign coreValWr = apbWr & (paddr == ADDR_CORE_VAL);
	assign auxCtlWr  = {apbWr & (paddr == ADDR_AUX2_CTL),
		apbWr & (paddr == ADDR_AUX1_CTL)};
	assign auxValWr  = {apbWr & (paddr == ADDR_AUX2_VAL),
		apbWr & (paddr == ADDR_AUX1_VAL)};
	assign mapped = (paddr == ADDR_CORE_CTL) | (paddr == ADDR_CORE_VAL) |
		(paddr == ADDR_AUX1_CTL) | (paddr == ADDR_AUX1_VAL) |
		(paddr == ADDR_AUX2_CTL) | (paddr == ADDR_AUX2_VAL);

	// ********************************************************
	// control registers
	// ********************************************************
	logic [15:0] coreCtl_q;
	logic [15:0] auxCtl_q [2];

	// R10 one layout for all
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			coreCtl_q <= CTL_RESET;
		end else if (coreCtlWr) begin
			coreCtl_q <= {4'h0, pwdata[OE_BIT], 2'b00, pwdata[8:0]};
		end
	end

	// ********************************************************
	// core timer step and direction
	// ********************************************************
	logic [2:0]  coreSel;
	qtb_mode_t   coreMode;
	logic        coreIncr;
	logic        coreTick;
	logic        coreStep;
	logic        coreDown;
	logic        coreUdDown;
	logic        coreGo;
	logic        coreOvf;
	logic [1:0]  coreQuad;
	logic [15:0] coreVal_q;

	assign coreSel  = coreCtl_q[SEL_LSB +: 3];
	assign coreMode = qtb_mode_t'(coreCtl_q[MODE_LSB +: 3]);
	assign coreTick = qtb_pre_tick(preCnt_q, coreSel);
	assign coreQuad = qtb_quad(coreSel, sRise[0], sFall[0], sRise[1],
		sFall[1], sLvl[0], sLvl[1]);
	// R7 external direction only when software enables it
	assign coreUdDown = coreCtl_q[UDE_BIT] ? (sLvl[1] ^ coreCtl_q[UD_BIT])
		: coreCtl_q[UD_BIT];
	// R1 encoder mode codes
	assign coreIncr = (coreMode == MODE_ROTATION) |
		(coreMode == MODE_EDGE);

	always_comb begin
		coreStep = 1'b0;
		coreDown = coreUdDown;
		unique case (coreMode)
			MODE_TIMER:   coreStep = coreTick;
			MODE_GATE_LO: coreStep = coreTick & ~sLvl[0];
			MODE_GATE_HI: coreStep = coreTick & sLvl[0];
			MODE_COUNTER: begin
				coreStep = ~coreSel[2] &
					qtb_edge(coreSel[1:0], sRise[0], sFall[0]);
			end
			// R2 edge select
			// R3 phase decode
			MODE_ROTATION, MODE_EDGE: begin
				coreStep = coreQuad[1];
				coreDown = coreQuad[0];
			end
			default: coreStep = 1'b0;
		endcase
	end

	// R19 run bit gates counting
	assign coreGo  = coreCtl_q[RUN_BIT] & coreStep;
	assign coreOvf = coreGo &
		(coreDown ? (coreVal_q == 16'h0000) : (coreVal_q == 16'hffff));

	// R21 wraps and keeps going
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			coreVal_q <= VAL_RESET;
		end else if (coreValWr) begin
			coreVal_q <= pwdata[15:0];
		end else if (coreGo) begin
			coreVal_q <= coreDown ? coreVal_q - 16'h0001
				: coreVal_q + 16'h0001;
		end
	end

	// ********************************************************
	// overflow toggle latch
	// ********************************************************
	logic otl_q;
	logic otlRise_q;
	logic otlFall_q;

	// R18 toggle on wrap, software write wins
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			otl_q <= 1'b0;
		end else if (coreCtlWr) begin
			otl_q <= pwdata[OTL_BIT];
		end else if (coreOvf) begin
			otl_q <= ~otl_q;
		end
	end

	// R14 pulses from wraps only
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			otlRise_q <= 1'b0;
			otlFall_q <= 1'b0;
		end else begin
			otlRise_q <= coreOvf & ~coreCtlWr & ~otl_q;
			otlFall_q <= coreOvf & ~coreCtlWr & otl_q;
		end
	end

	// ********************************************************
	// encoder status flags and interrupt
	// ********************************************************
	logic rdir_q;
	logic chdir_q;
	logic edgeFlag_q;
	logic dirChg;

	assign dirChg = coreIncr & coreGo & (coreDown != rdir_q);

	// R6 status bits, set beats clear
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdir_q     <= 1'b0;
			chdir_q    <= 1'b0;
			edgeFlag_q <= 1'b0;
		end else begin
			if (coreIncr && coreGo) begin
				rdir_q <= coreDown;
			end
			if (dirChg) begin
				chdir_q <= 1'b1;
			end else if (coreCtlWr && !pwdata[CHDIR_BIT]) begin
				chdir_q <= 1'b0;
			end
			if (coreIncr && coreGo) begin
				edgeFlag_q <= 1'b1;
			end else if (coreCtlWr && !pwdata[EDGE_BIT]) begin
				edgeFlag_q <= 1'b0;
			end
		end
	end

	// R4 rotation request
	// R5 edge request
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			coreIrq   <= 1'b0;
			toggleOut <= 1'b0;
		end else begin
			coreIrq <= ((coreMode == MODE_ROTATION) & dirChg) |
				((coreMode == MODE_EDGE) & coreIncr & coreGo);
			toggleOut <= otl_q & coreCtl_q[OE_BIT];
		end
	end

	// ********************************************************
	// auxiliary timers
	// ********************************************************
	logic [15:0] auxVal [2];

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_aux
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					auxCtl_q[g] <= CTL_RESET;
				end else if (auxCtlWr[g]) begin
					auxCtl_q[g] <= {6'h00, pwdata[9:0]};
				end
			end

			// R11 core run passed for remote control
			// R15 latch pulses clock the upper half
			qtb_aux_timer u_aux (
				.clk_sys (clk_sys),
				.rst_b   (rst_b),
				.ctl     (auxCtl_q[g]),
				.coreRun (coreCtl_q[RUN_BIT]),
				.preCnt  (preCnt_q),
				.inLvl   (sLvl[2*g+2]),
				.inRise  (sRise[2*g+2]),
				.inFall  (sFall[2*g+2]),
				.dirLvl  (sLvl[2*g+3]),
				.dirRise (sRise[2*g+3]),
				.dirFall (sFall[2*g+3]),
				.otlRise (otlRise_q),
				.otlFall (otlFall_q),
				.loadEn  (auxValWr[g]),
				.loadData(pwdata[15:0]),
				.count   (auxVal[g])
			);
		end
	endgenerate

	// ********************************************************
	// apb answer
	// ********************************************************
	logic [31:0] rdMux;

	always_comb begin
		rdMux = 32'h0000_0000;
		unique case (paddr)
			ADDR_CORE_CTL: rdMux = {17'h00000, edgeFlag_q, chdir_q,
				rdir_q, coreCtl_q[OE_BIT], otl_q, 1'b0,
				coreCtl_q[8:0]};
			ADDR_CORE_VAL: rdMux = {16'h0000, coreVal_q};
			ADDR_AUX1_CTL: rdMux = {16'h0000, auxCtl_q[0]};
			ADDR_AUX1_VAL: rdMux = {16'h0000, auxVal[0]};
			ADDR_AUX2_CTL: rdMux = {16'h0000, auxCtl_q[1]};
			ADDR_AUX2_VAL: rdMux = {16'h0000, auxVal[1]};
			default:       rdMux = 32'h0000_0000;
		endcase
	end

	// answered in the first access cycle; data taken at setup
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			if (psel && !penable) begin
				prdata <= rdMux;
			end
		end
	end

	// ********************************************************
	// assertions
	// ********************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_apb_ready_setup: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("pready not one cycle after setup");

	a_mode_no_irq: assert property ( // R1
		!coreIncr |=> !coreIrq)
		else $error("interrupt outside encoder mode");

	a_sel_none_stop: assert property ( // R2
		coreIncr && coreSel == 3'b000 && !coreValWr |=> $stable(coreVal_q))
		else $error("encoder counted with select zero");

	a_phase_down_count: assert property ( // R3
		coreIncr && coreCtl_q[RUN_BIT] && coreSel == 3'b001 && sRise[0]
		&& sLvl[1] && !coreValWr |=> coreVal_q == $past(coreVal_q) - 16'h1)
		else $error("rising count input with high phase not down");

	a_rot_irq: assert property ( // R4
		coreMode == MODE_ROTATION && dirChg |=> coreIrq)
		else $error("direction change gave no interrupt");

	a_edge_irq: assert property ( // R5
		coreMode == MODE_EDGE && coreGo |=> coreIrq && edgeFlag_q)
		else $error("count action gave no interrupt");

	a_chdir_flag: assert property ( // R6
		dirChg |=> chdir_q && rdir_q == $past(coreDown))
		else $error("direction flags wrong");

	a_latch_pulse_sw: assert property ( // R14
		coreCtlWr |=> !otlRise_q && !otlFall_q)
		else $error("software latch write clocked aux");

	a_otl_toggle: assert property ( // R18
		coreOvf && !coreCtlWr |=> otl_q != $past(otl_q)
		&& (otlRise_q || otlFall_q))
		else $error("overflow did not toggle latch");

	a_run_hold: assert property ( // R19
		!coreCtl_q[RUN_BIT] && !coreValWr |=> $stable(coreVal_q))
		else $error("core counted while stopped");

	a_wrap_up: assert property ( // R21
		coreGo && !coreDown && coreVal_q == 16'hffff && !coreValWr
		|=> coreVal_q == 16'h0000)
		else $error("core did not wrap to zero");

endmodule : qtb_timer_block
`default_nettype wire

// file: hw/qtb_pkg.sv
// constants, types and helpers shared by the quadrature timer block
package qtb_pkg;

	// ********************************************************
	// register byte offsets
	// ********************************************************
	localparam logic [7:0] ADDR_CORE_CTL = 8'h00;
	localparam logic [7:0] ADDR_CORE_VAL = 8'h04;
	localparam logic [7:0] ADDR_AUX1_CTL = 8'h08;
	localparam logic [7:0] ADDR_AUX1_VAL = 8'h0c;
	localparam logic [7:0] ADDR_AUX2_CTL = 8'h10;
	localparam logic [7:0] ADDR_AUX2_VAL = 8'h14;

	// ********************************************************
	// control field positions, same in every timer
	// ********************************************************
	localparam int SEL_LSB   = 0;
	localparam int MODE_LSB  = 3;
	localparam int RUN_BIT   = 6;
	localparam int UD_BIT    = 7;
	localparam int UDE_BIT   = 8;
	localparam int RC_BIT    = 9;
	localparam int OTL_BIT   = 10;
	localparam int OE_BIT    = 11;
	localparam int RDIR_BIT  = 12;
	localparam int CHDIR_BIT = 13;
	localparam int EDGE_BIT  = 14;

	// ********************************************************
	// reset values and widths
	// ********************************************************
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [15:0] VAL_RESET = 16'h0000;
	localparam int          PRE_WIDTH = 10;
	localparam int          PIN_COUNT = 6;

	typedef enum logic [2:0] {
		MODE_TIMER    = 3'b000,
		MODE_COUNTER  = 3'b001,
		MODE_GATE_LO  = 3'b010,
		MODE_GATE_HI  = 3'b011,
		MODE_ROTATION = 3'b110,
		MODE_EDGE     = 3'b111
	} qtb_mode_t;

	// prescaler tick: factor 8 * 2^sel
	function automatic logic qtb_pre_tick(input logic [9:0] pre,
		input logic [2:0] sel);
		logic [9:0] mask;
		mask = (10'h008 << sel) - 10'h001;
		return &(pre | ~mask);
	endfunction : qtb_pre_tick

	// counter mode edge pick: 01 rise, 10 fall, 11 any
	function automatic logic qtb_edge(input logic [1:0] sel,
		input logic rise, input logic fall);
		return (sel[0] & rise) | (sel[1] & fall);
	endfunction : qtb_edge

	// encoder decode, returns {step, down}
	function automatic logic [1:0] qtb_quad(input logic [2:0] sel,
		input logic inR, input logic inF, input logic dR,
		input logic dF, input logic inL, input logic dL);
		logic useIn;
		logic useDir;
		useIn  = ~sel[2] & sel[0] & (inR | inF);
		useDir = ~sel[2] & sel[1] & (dR | dF);
		if (useIn) begin
			return {1'b1, inR ? dL : ~dL};
		end
		if (useDir) begin
			return {1'b1, dR ? ~inL : inL};
		end
		return 2'b00;
	endfunction : qtb_quad

endpackage : qtb_pkg

// file: hw/qtb_pin_sync.sv
// three-stage pin synchroniser with filtered level and edge pulses
`timescale 1ns/100ps
`default_nettype none
module qtb_pin_sync
	import qtb_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] lvl,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
					s3_q[i] <= 1'b0;
					lvl[i]  <= 1'b0;
					rise[i] <= 1'b0;
					fall[i] <= 1'b0;
				end else begin
					s1_q[i] <= pinIn[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					// level and edge change together, so decode sees both
					if (s2_q[i] == s3_q[i]) begin
						lvl[i] <= s3_q[i];
					end
					rise[i] <= (s2_q[i] == s3_q[i]) & s3_q[i] & ~lvl[i];
					fall[i] <= (s2_q[i] == s3_q[i]) & ~s3_q[i] & lvl[i];
				end
			end
		end
	endgenerate
endmodule : qtb_pin_sync
`default_nettype wire

// file: hw/qtb_aux_timer.sv
// auxiliary 16-bit timer: timer, gated, counter and encoder modes
`timescale 1ns/100ps
`default_nettype none
module qtb_aux_timer
	import qtb_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [15:0] ctl,
	input  wire logic        coreRun,
	input  wire logic [9:0]  preCnt,
	input  wire logic        inLvl,
	input  wire logic        inRise,
	input  wire logic        inFall,
	input  wire logic        dirLvl,
	input  wire logic        dirRise,
	input  wire logic        dirFall,
	input  wire logic        otlRise,
	input  wire logic        otlFall,
	input  wire logic        loadEn,
	input  wire logic [15:0] loadData,
	output logic      [15:0] count
);
	logic [2:0] sel;
	qtb_mode_t  mode;
	logic       run;
	logic       tick;
	logic       udDown;
	logic       step;
	logic       down;
	logic [1:0] quad;

	assign sel  = ctl[SEL_LSB +: 3];
	assign mode = qtb_mode_t'(ctl[MODE_LSB +: 3]);
	assign tick = qtb_pre_tick(preCnt, sel);
	assign quad = qtb_quad(sel, inRise, inFall, dirRise, dirFall,
		inLvl, dirLvl);
	// R11 remote run select
	assign run    = ctl[RC_BIT] ? coreRun : ctl[RUN_BIT];
	assign udDown = ctl[UDE_BIT] ? (dirLvl ^ ctl[UD_BIT]) : ctl[UD_BIT];

	// R9 same modes as core
	always_comb begin
		step = 1'b0;
		down = udDown;
		unique case (mode)
			// R12 no output line or latch here
			MODE_TIMER:   step = tick;
			MODE_GATE_LO: step = tick & ~inLvl;
			MODE_GATE_HI: step = tick & inLvl;
			MODE_COUNTER: begin
				// R13 input or latch edges
				// R15 both edges 32 bit, one edge 33 bit
				if (sel[2]) begin
					step = qtb_edge(sel[1:0], otlRise, otlFall);
				end else begin
					step = qtb_edge(sel[1:0], inRise, inFall);
				end
			end
			MODE_ROTATION, MODE_EDGE: begin
				step = quad[1];
				down = quad[0];
			end
			default: step = 1'b0;
		endcase
	end

	// R16 sixteen bit count
	// R17 own direction kept
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			count <= VAL_RESET;
		end else if (loadEn) begin
			count <= loadData;
		end else if (run && step) begin
			count <= down ? count - 16'h0001 : count + 16'h0001;
		end
	end
endmodule : qtb_aux_timer
`default_nettype wire

// file: testbench/qtb_enc_model.sv
// two-phase incremental encoder model driving the core timer pins
`timescale 1ns/100ps
`default_nettype none
module qtb_enc_model (
	input  wire logic clk_sys,
	output logic      phA,
	output logic      phB
);
	// ****************************************
	// phase walk
	// ****************************************
	int p;
	initial begin
		p = 0;
		phA = 1'b0;
		phB = 1'b0;
	end
	// one encoder step, forward counts up
	task automatic step(input bit fwd);
		@(posedge clk_sys);
		p = fwd ? (p + 1) % 4 : (p + 3) % 4;
		// order 00 10 11 01 counts up
		phA <= (p == 1) || (p == 2);
		phB <= (p >= 2);
		// level held nine clocks between steps, rate clk/9
		repeat (8) @(posedge clk_sys);
	endtask : step
endmodule : qtb_enc_model
`default_nettype wire

// file: testbench/qtb_timer_block_test.sv
// self-checking bench of the quadrature timer block
`timescale 1ns/100ps
`default_nettype none
module qtb_timer_block_test
	import qtb_pkg::*;
;
	// ****************************************
	// signals and instances
	// ****************************************
	localparam int RUN = 1 << RUN_BIT;
	localparam int UD  = 1 << UD_BIT;
	localparam int UDE = 1 << UDE_BIT;
	localparam int RC  = 1 << RC_BIT;
	localparam int OTL = 1 << OTL_BIT;
	localparam int OE  = 1 << OE_BIT;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        phA;
	logic        phB;
	logic        aux1Cnt = 1'b0;
	logic        aux1Dir = 1'b0;
	logic        aux2Cnt = 1'b0;
	logic        aux2Dir = 1'b0;
	logic        toggleOut;
	logic        coreIrq;
	int          fail_count = 0;
	int          checks_done = 0;
	int          irqCount = 0;
	int          base;
	logic [31:0] r;
	logic        e;
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (coreIrq === 1'b1) irqCount++;
	qtb_enc_model enc (.clk_sys(clk_sys), .phA(phA), .phB(phB));
	qtb_timer_block dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .coreCountIn(phA), .coreDirIn(phB),
		.aux1CountIn(aux1Cnt), .aux1DirIn(aux1Dir),
		.aux2CountIn(aux2Cnt), .aux2DirIn(aux2Dir),
		.toggleOut(toggleOut), .coreIrq(coreIrq)
	);
	// ****************************************
	// shared tasks
	// ****************************************
	function automatic logic [31:0] mk(input int s, input int m,
		input int b);
		return 32'((s << SEL_LSB) | (m << MODE_LSB) | b);
	endfunction : mk
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// apb transfer, waits for pready; only the watchdog ends a hang
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		xfer(1'b0, a, 32'h0);
		chk(r, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask : rd
	// ****************************************
	// scenarios
	// ****************************************
	task automatic testReset;
		for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, 1'b0);
		wr(8'h18, 32'h0000ffff);
		rd(8'h18, 32'h0, 1'b1);
		rd(8'h02, 32'h0, 1'b1);
	endtask : testReset
	task automatic testRotation;
		base = irqCount;
		wr(ADDR_CORE_CTL, mk(1, 6, RUN | UDE));
		repeat (3) enc.step(1);
		rd(ADDR_CORE_VAL, 32'h2, 1'b0);
		chk(irqCount - base, 0);
		enc.step(0);
		rd(ADDR_CORE_VAL, 32'h1, 1'b0);
		chk(irqCount - base, 1);
		xfer(1'b0, ADDR_CORE_CTL, 32'h0);
		chk(r[RDIR_BIT], 1);
		chk(r[CHDIR_BIT], 1);
		// direction-phase edge is not counted with select 001
		repeat (2) enc.step(0);
		rd(ADDR_CORE_VAL, 32'h0, 1'b0);
	endtask : testRotation
	task automatic testEdge;
		wr(ADDR_CORE_CTL, mk(3, 7, RUN | UDE));
		base = irqCount;
		repeat (4) enc.step(1);
		rd(ADDR_CORE_VAL, 32'h4, 1'b0);
		chk(irqCount - base, 4);
		xfer(1'b0, ADDR_CORE_CTL, 32'h0);
		chk(r[EDGE_BIT], 1);
		chk(r[RDIR_BIT], 0);
		wr(ADDR_CORE_CTL, mk(0, 7, RUN | UDE));
		base = irqCount;
		repeat (4) enc.step(1);
		rd(ADDR_CORE_VAL, 32'h4, 1'b0);
		chk(irqCount - base, 0);
		wr(ADDR_CORE_CTL, mk(3, 7, RUN | UDE));
		repeat (4) enc.step(0);
		rd(ADDR_CORE_VAL, 32'h0, 1'b0);
	endtask : testEdge
	task automatic testConcat;
		wr(ADDR_AUX1_CTL, mk(7, 1, RUN | UD));
		wr(ADDR_AUX2_CTL, mk(5, 1, RC));
		wr(ADDR_CORE_CTL, mk(1, 1, RUN));
		wr(ADDR_CORE_VAL, 32'h0000ffff);
		repeat (4) enc.step(1);
		rd(ADDR_CORE_VAL, 32'h0, 1'b0);
		rd(ADDR_AUX1_VAL, 32'h0000ffff, 1'b0);
		rd(ADDR_AUX2_VAL, 32'h1, 1'b0);
		xfer(1'b0, ADDR_CORE_CTL, 32'h0);
		chk(r[OTL_BIT], 1);
		wr(ADDR_CORE_VAL, 32'h0000ffff);
		repeat (4) enc.step(1);
		rd(ADDR_AUX1_VAL, 32'h0000fffe, 1'b0);
		rd(ADDR_AUX2_VAL, 32'h1, 1'b0);
		wr(ADDR_CORE_CTL, mk(1, 1, RUN | OE | OTL));
		repeat (2) @(posedge clk_sys);
		chk({31'h0, toggleOut}, 32'h1);
		rd(ADDR_AUX1_VAL, 32'h0000fffe, 1'b0);
		rd(ADDR_AUX2_VAL, 32'h1, 1'b0);
		wr(ADDR_CORE_CTL, mk(1, 1, OTL));
		repeat (4) enc.step(1);
		rd(ADDR_CORE_VAL, 32'h0, 1'b0);
	endtask : testConcat
	task automatic testAux;
		wr(ADDR_AUX1_CTL, mk(1, 1, RUN | UDE));
		wr(ADDR_AUX1_VAL, 32'h0);
		// three rising edges up, the fourth with direction pin high
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			aux1Dir <= (i == 3);
			aux1Cnt <= 1'b1;
			repeat (8) @(posedge clk_sys);
			aux1Cnt <= 1'b0;
			repeat (8) @(posedge clk_sys);
		end
		rd(ADDR_AUX1_VAL, 32'h2, 1'b0);
		wr(ADDR_AUX2_CTL, mk(3, 6, RUN | UDE));
		wr(ADDR_AUX2_VAL, 32'h0);
		// forward encoder walk on the second aux pins
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			aux2Cnt <= (i == 0) || (i == 1);
			aux2Dir <= (i >= 1) && (i <= 2);
			repeat (8) @(posedge clk_sys);
		end
		rd(ADDR_AUX2_VAL, 32'h4, 1'b0);
		wr(ADDR_AUX1_CTL, mk(0, 3, RUN));
		repeat (40) @(posedge clk_sys);
		rd(ADDR_AUX1_VAL, 32'h2, 1'b0);
		// 81 edges at factor 8 give ten or eleven ticks
		wr(ADDR_AUX1_CTL, mk(0, 0, RUN));
		repeat (80) @(posedge clk_sys);
		xfer(1'b0, ADDR_AUX1_VAL, 32'h0);
		checks_done++;
		if (r !== 32'h0000000c && r !== 32'h0000000d) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, r, 32'h0000000c);
		end
	endtask : testAux
	// ****************************************
	// run control
	// ****************************************
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	initial begin
		#100000;
		fail_count++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		testReset();
		testRotation();
		testEdge();
		testConcat();
		testAux();
		print_verdict();
	end
endmodule : qtb_timer_block_test
`default_nettype wire
